// ### rtl/dual_dot_pkg.sv
package dual_dot_pkg;

   localparam int WORD_WIDTH = 32;
   localparam int HALF_WIDTH = 16;
   localparam int BYTE_WIDTH = 8;
   localparam int SUM_WIDTH = 34;
   localparam int RESULT_LATENCY = 4;
   localparam logic [SUM_WIDTH-1:0] ROUND_ADD = 34'h000008000;
   localparam logic [WORD_WIDTH-1:0] SAT_POS_WORD = 32'h7fffffff;
   localparam logic [WORD_WIDTH-1:0] SAT_NEG_WORD = 32'h80000000;
   localparam int SSR_SIDE_A_BIT = 4;
   localparam int SSR_SIDE_B_BIT = 5;
   localparam int CSR_SAT_BIT = 9;
   localparam logic [WORD_WIDTH-1:0] SSR_RESET = 32'h00000000;
   localparam logic CSR_SAT_RESET = 1'b0;

   typedef enum logic [1:0] {
      byte_halfword_dual_dot,
      high_pair_dual_dot,
      high_pair_dual_dot_rounded,
      low_pair_dual_dot
   } dot_op_type;

endpackage

// ### rtl/packed_dual_dot_product_unit.sv
// What this block does
// [RULE1] Byte dot: even word uses bytes of second operand's low halfword, sign-extended.
// [RULE2] Byte dot: odd word uses bytes of second operand's high halfword instead.
// [RULE3] Byte dot never saturates and never touches any saturation flag.
// [RULE4] Halfword pair dot: signed 16-bit inputs, two signed results to a word pair.
// [RULE5] High pair odd word: low-times-low plus high-times-high of odd word and operand.
// [RULE6] High pair even word: op high times odd low plus op low times even high.
// [RULE7] Rounded: add 0x8000 to odd sum, saturate, upper half into result upper half.
// [RULE8] Rounded: add 0x8000 to mixed sum, saturate, upper half into result lower half.
// [RULE9] Results appear four cycles after issue; older contents stand during three slots.
// [RULE10] On saturation set unit status bit and control bit one cycle after write.
// [RULE11] Side A status bit 4, side B bit 5, control saturation bit 9.
// [RULE12] Without saturation both flag bits keep their prior values.
// [RULE13] Predicates are ignored; every issued operation executes.
// [RULE14] Overflowing 32-bit signed sums clamp to the extreme matching the true sign.
// [RULE15] Low pair even word: even word halves times matching operand halves, summed.
module packed_dual_dot_product_unit
   import dual_dot_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic issue_valid_in,
   input wire dot_op_type op_in,
   input wire logic side_b_in,
   input wire logic predicate_in,
   input wire logic [WORD_WIDTH-1:0] even_source_word_in,
   input wire logic [WORD_WIDTH-1:0] odd_source_word_in,
   input wire logic [WORD_WIDTH-1:0] operand_in,
   input wire logic status_clear_a_in,
   input wire logic status_clear_b_in,
   input wire logic control_sat_clear_in,
   output logic result_valid_out,
   output logic result_pair_out,
   output logic [WORD_WIDTH-1:0] result_even_out,
   output logic [WORD_WIDTH-1:0] result_odd_out,
   output logic [WORD_WIDTH-1:0] saturation_status_reg_out,
   output logic [WORD_WIDTH-1:0] control_status_reg_out
);

   function automatic logic signed [SUM_WIDTH-1:0] mul_half(input logic [HALF_WIDTH-1:0] a,
                                                           input logic [HALF_WIDTH-1:0] b);
      logic signed [WORD_WIDTH-1:0] p;
      p = $signed(a) * $signed(b);
      mul_half = SUM_WIDTH'(p);
   endfunction

   function automatic logic [HALF_WIDTH-1:0] sext_byte(input logic [BYTE_WIDTH-1:0] b);
      sext_byte = {{(HALF_WIDTH-BYTE_WIDTH){b[BYTE_WIDTH-1]}}, b};
   endfunction

   function automatic logic [HALF_WIDTH-1:0] lo(input logic [WORD_WIDTH-1:0] w);
      lo = w[HALF_WIDTH-1:0];
   endfunction

   function automatic logic [HALF_WIDTH-1:0] hi(input logic [WORD_WIDTH-1:0] w);
      hi = w[WORD_WIDTH-1:HALF_WIDTH];
   endfunction

   // The predicate is deliberately left unread: these operations run unconditionally
   wire logic issue_go;
   assign issue_go = issue_valid_in; // [RULE13]

   // Every halfword product has a named wire; the sums below only pick and add them
   wire logic signed [SUM_WIDTH-1:0] byte_even_lo_prod;
   wire logic signed [SUM_WIDTH-1:0] byte_even_hi_prod;
   wire logic signed [SUM_WIDTH-1:0] byte_odd_lo_prod;
   wire logic signed [SUM_WIDTH-1:0] byte_odd_hi_prod;
   wire logic signed [SUM_WIDTH-1:0] odd_lo_prod;
   wire logic signed [SUM_WIDTH-1:0] odd_hi_prod;
   wire logic signed [SUM_WIDTH-1:0] cross_odd_prod;
   wire logic signed [SUM_WIDTH-1:0] cross_even_prod;
   wire logic signed [SUM_WIDTH-1:0] even_lo_prod;
   wire logic signed [SUM_WIDTH-1:0] even_hi_prod;

   assign byte_even_lo_prod = mul_half(lo(even_source_word_in), sext_byte(operand_in[7:0]));
   assign byte_even_hi_prod = mul_half(hi(even_source_word_in), sext_byte(operand_in[15:8]));
   assign byte_odd_lo_prod = mul_half(lo(even_source_word_in), sext_byte(operand_in[23:16]));
   assign byte_odd_hi_prod = mul_half(hi(even_source_word_in), sext_byte(operand_in[31:24]));
   assign odd_lo_prod = mul_half(lo(odd_source_word_in), lo(operand_in));
   assign odd_hi_prod = mul_half(hi(odd_source_word_in), hi(operand_in));
   assign cross_odd_prod = mul_half(hi(operand_in), lo(odd_source_word_in));
   assign cross_even_prod = mul_half(lo(operand_in), hi(even_source_word_in));
   assign even_lo_prod = mul_half(lo(even_source_word_in), lo(operand_in));
   assign even_hi_prod = mul_half(hi(even_source_word_in), hi(operand_in));

   wire logic signed [SUM_WIDTH-1:0] byte_even_sum;
   wire logic signed [SUM_WIDTH-1:0] byte_odd_sum;
   wire logic signed [SUM_WIDTH-1:0] high_odd_sum;
   wire logic signed [SUM_WIDTH-1:0] mixed_sum;
   wire logic signed [SUM_WIDTH-1:0] low_even_sum;

   assign byte_even_sum = byte_even_lo_prod + byte_even_hi_prod; // [RULE1]
   assign byte_odd_sum = byte_odd_lo_prod + byte_odd_hi_prod; // [RULE2]
   assign high_odd_sum = odd_lo_prod + odd_hi_prod; // [RULE5]
   assign mixed_sum = cross_odd_prod + cross_even_prod; // [RULE6]
   assign low_even_sum = even_lo_prod + even_hi_prod; // [RULE15]

   wire logic round_en;
   assign round_en = (op_in == high_pair_dual_dot_rounded);

   // Even/odd slot inputs to the saturators, chosen per operation
   logic signed [SUM_WIDTH-1:0] slot_a_sum;
   logic signed [SUM_WIDTH-1:0] slot_b_sum;
   always_comb
   begin
      case (op_in)
         high_pair_dual_dot, high_pair_dual_dot_rounded:
         begin
            slot_a_sum = mixed_sum;
            slot_b_sum = high_odd_sum;
         end
         low_pair_dual_dot:
         begin
            slot_a_sum = low_even_sum;
            slot_b_sum = mixed_sum;
         end
         default:
         begin
            slot_a_sum = byte_even_sum;
            slot_b_sum = byte_odd_sum;
         end
      endcase
   end

   wire logic [WORD_WIDTH-1:0] slot_a_word;
   wire logic [WORD_WIDTH-1:0] slot_b_word;
   wire logic slot_a_sat;
   wire logic slot_b_sat;

   sat_round sat_even
   (
      .sum_in(slot_a_sum),
      .round_in(round_en),
      .result_out(slot_a_word),
      .sat_out(slot_a_sat)
   );

   sat_round sat_odd
   (
      .sum_in(slot_b_sum),
      .round_in(round_en),
      .result_out(slot_b_word),
      .sat_out(slot_b_sat)
   );

   wire logic is_byte_op;
   assign is_byte_op = (op_in == byte_halfword_dual_dot);

   // Byte sums stay far inside 32 bits, so the raw low word is exact
   logic [WORD_WIDTH-1:0] stage_even;
   logic [WORD_WIDTH-1:0] stage_odd;
   always_comb
   begin
      case (op_in)
         byte_halfword_dual_dot:
         begin
            stage_even = byte_even_sum[WORD_WIDTH-1:0]; // [RULE3]
            stage_odd = byte_odd_sum[WORD_WIDTH-1:0];
         end
         high_pair_dual_dot_rounded:
         begin
            stage_even = {slot_b_word[WORD_WIDTH-1:HALF_WIDTH], slot_a_word[WORD_WIDTH-1:HALF_WIDTH]}; // [RULE7] [RULE8]
            stage_odd = '0;
         end
         default:
         begin
            stage_even = slot_a_word; // [RULE4]
            stage_odd = slot_b_word;
         end
      endcase
   end

   wire logic stage_sat;
   assign stage_sat = !is_byte_op && (slot_a_sat || slot_b_sat); // [RULE3]

   wire logic stage_pair;
   assign stage_pair = (op_in != high_pair_dual_dot_rounded);

   // Arithmetic is done in the first stage; the remaining stages only age the result
   // Data needs one stage less than control, as the output flops form its last stage
   logic [WORD_WIDTH-1:0] even_ff [RESULT_LATENCY-1];
   logic [WORD_WIDTH-1:0] odd_ff [RESULT_LATENCY-1];
   logic [RESULT_LATENCY-1:0] valid_ff;
   logic [RESULT_LATENCY-1:0] sat_ff;
   logic [RESULT_LATENCY-1:0] side_ff;
   logic [RESULT_LATENCY-1:0] pair_ff;

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         valid_ff <= '0;
         sat_ff <= '0;
         side_ff <= '0;
         pair_ff <= '0;
      end
      else
      begin
         valid_ff <= {valid_ff[RESULT_LATENCY-2:0], issue_go}; // [RULE9]
         sat_ff <= {sat_ff[RESULT_LATENCY-2:0], issue_go && stage_sat};
         side_ff <= {side_ff[RESULT_LATENCY-2:0], side_b_in};
         pair_ff <= {pair_ff[RESULT_LATENCY-2:0], stage_pair};
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < RESULT_LATENCY-1; i++)
         begin
            even_ff[i] <= '0;
            odd_ff[i] <= '0;
         end
      end
      else
      begin
         even_ff[0] <= stage_even;
         odd_ff[0] <= stage_odd;
         for (int i = 1; i < RESULT_LATENCY-1; i++)
         begin
            even_ff[i] <= even_ff[i-1];
            odd_ff[i] <= odd_ff[i-1];
         end
      end
   end

   // Outputs only advance on a new result, so consumers see old values in the delay slots
   logic [WORD_WIDTH-1:0] out_even_ff;
   logic [WORD_WIDTH-1:0] out_odd_ff;
   logic out_pair_ff;
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         out_even_ff <= '0;
         out_odd_ff <= '0;
         out_pair_ff <= 1'b0;
      end
      else if (valid_ff[RESULT_LATENCY-2])
      begin
         out_even_ff <= even_ff[RESULT_LATENCY-2]; // [RULE9]
         out_odd_ff <= odd_ff[RESULT_LATENCY-2];
         out_pair_ff <= pair_ff[RESULT_LATENCY-2];
      end
   end

   assign result_valid_out = valid_ff[RESULT_LATENCY-1];
   assign result_even_out = out_even_ff;
   assign result_odd_out = out_odd_ff;
   assign result_pair_out = out_pair_ff;

   // Flags are set one cycle after the result lands; a set wins over a same-cycle clear
   wire logic set_a;
   wire logic set_b;
   assign set_a = sat_ff[RESULT_LATENCY-1] && !side_ff[RESULT_LATENCY-1]; // [RULE10]
   assign set_b = sat_ff[RESULT_LATENCY-1] && side_ff[RESULT_LATENCY-1]; // [RULE10]

   logic ssr_a_ff;
   logic ssr_b_ff;
   logic csr_sat_ff;
   wire logic nxt_ssr_a;
   wire logic nxt_ssr_b;
   wire logic nxt_csr_sat;
   assign nxt_ssr_a = set_a || (ssr_a_ff && !status_clear_a_in); // [RULE12]
   assign nxt_ssr_b = set_b || (ssr_b_ff && !status_clear_b_in); // [RULE12]
   assign nxt_csr_sat = set_a || set_b || (csr_sat_ff && !control_sat_clear_in); // [RULE12]

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ssr_a_ff <= SSR_RESET[SSR_SIDE_A_BIT];
      end
      else
      begin
         ssr_a_ff <= nxt_ssr_a;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ssr_b_ff <= SSR_RESET[SSR_SIDE_B_BIT];
      end
      else
      begin
         ssr_b_ff <= nxt_ssr_b;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         csr_sat_ff <= CSR_SAT_RESET;
      end
      else
      begin
         csr_sat_ff <= nxt_csr_sat;
      end
   end

   always_comb
   begin
      saturation_status_reg_out = '0;
      saturation_status_reg_out[SSR_SIDE_A_BIT] = ssr_a_ff; // [RULE11]
      saturation_status_reg_out[SSR_SIDE_B_BIT] = ssr_b_ff; // [RULE11]
      control_status_reg_out = '0;
      control_status_reg_out[CSR_SAT_BIT] = csr_sat_ff; // [RULE11]
   end

endmodule

// ### rtl/sat_round.sv
module sat_round
   import dual_dot_pkg::*;
(
   input wire logic signed [SUM_WIDTH-1:0] sum_in,
   input wire logic round_in,
   output logic [WORD_WIDTH-1:0] result_out,
   output logic sat_out
);

   wire logic signed [SUM_WIDTH-1:0] rounded;
   wire logic over_pos;
   wire logic over_neg;

   assign rounded = round_in ? sum_in + $signed(ROUND_ADD) : sum_in;
   assign over_pos = !rounded[SUM_WIDTH-1] && (rounded[SUM_WIDTH-2:WORD_WIDTH-1] != '0);
   assign over_neg = rounded[SUM_WIDTH-1] && (rounded[SUM_WIDTH-2:WORD_WIDTH-1] != '1);
   // Clamp toward the sign of the true sum
   assign result_out = over_pos ? SAT_POS_WORD : (over_neg ? SAT_NEG_WORD : rounded[WORD_WIDTH-1:0]); // [RULE14]
   assign sat_out = over_pos || over_neg;

endmodule

// ### verification/core_issue_model.sv
module core_issue_model
   import dual_dot_pkg::*;
(
   input wire logic mclk_in,
   output logic issue_valid_out,
   output dot_op_type op_out,
   output logic side_b_out,
   output logic predicate_out,
   output logic [WORD_WIDTH-1:0] even_out,
   output logic [WORD_WIDTH-1:0] odd_out,
   output logic [WORD_WIDTH-1:0] operand_out
);
   initial
   begin
      issue_valid_out = 1'b0;
      op_out = byte_halfword_dual_dot;
      side_b_out = 1'b0;
      predicate_out = 1'b0;
      even_out = '0;
      odd_out = '0;
      operand_out = '0;
   end
   task automatic issue(input dot_op_type op, input logic side, input logic [31:0] e, o, b);
      @(negedge mclk_in);
      issue_valid_out = 1'b1;
      op_out = op;
      side_b_out = side;
      // Predicate flips every issue so a false one must still execute
      predicate_out = ~predicate_out;
      even_out = e;
      odd_out = o;
      operand_out = b;
   endtask
   task automatic idle();
      @(negedge mclk_in);
      issue_valid_out = 1'b0;
      even_out = ~even_out;
      odd_out = ~odd_out;
      operand_out = ~operand_out;
   endtask
endmodule

// ### verification/packed_dual_dot_checker.sv
module packed_dual_dot_checker
   import dual_dot_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic issue_valid_in,
   input wire dot_op_type op_in,
   input wire logic side_b_in,
   input wire logic status_clear_a_in,
   input wire logic result_valid_out,
   input wire logic result_pair_out,
   input wire logic [WORD_WIDTH-1:0] result_even_out,
   input wire logic [WORD_WIDTH-1:0] result_odd_out,
   input wire logic [WORD_WIDTH-1:0] saturation_status_reg_out,
   input wire logic [WORD_WIDTH-1:0] control_status_reg_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   a_result_on_time: assert property (issue_valid_in |-> ##4 result_valid_out) else $error("late");
   a_no_stray: assert property (result_valid_out |-> $past(issue_valid_in, 4)) else $error("stray");
   a_old_stands: assert property ($changed(result_even_out) |-> result_valid_out) else $error("early");
   a_pair_kind: assert property (result_valid_out |-> result_pair_out ==
      ($past(op_in, 4) != high_pair_dual_dot_rounded)) else $error("pair kind");
   a_packed_odd: assert property (result_valid_out && !result_pair_out |-> result_odd_out == '0)
      else $error("packed odd");
   a_byte_no_flag: assert property (result_valid_out && $past(op_in, 4) == byte_halfword_dual_dot |=>
      $stable(saturation_status_reg_out) && $stable(control_status_reg_out)) else $error("byte flag");
   a_side_a_cause: assert property ($rose(saturation_status_reg_out[SSR_SIDE_A_BIT]) |->
      $past(result_valid_out) && !$past(side_b_in, 5)) else $error("side a");
   a_flag_sticky: assert property ($fell(saturation_status_reg_out[SSR_SIDE_A_BIT]) |->
      $past(status_clear_a_in)) else $error("sticky");
   a_ctrl_follows: assert property ($rose(saturation_status_reg_out[SSR_SIDE_B_BIT]) |->
      control_status_reg_out[CSR_SAT_BIT] && $past(result_valid_out)) else $error("ctrl");
   a_spare_bits: assert property ((saturation_status_reg_out & ~32'h00000030) == '0 &&
      (control_status_reg_out & ~32'h00000200) == '0) else $error("spare");
endmodule

bind packed_dual_dot_product_unit packed_dual_dot_checker i_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
   .issue_valid_in(issue_valid_in), .op_in(op_in), .side_b_in(side_b_in), .status_clear_a_in(status_clear_a_in),
   .result_valid_out(result_valid_out), .result_pair_out(result_pair_out), .result_even_out(result_even_out),
   .result_odd_out(result_odd_out), .saturation_status_reg_out(saturation_status_reg_out),
   .control_status_reg_out(control_status_reg_out));

// ### verification/packed_dual_dot_product_unit_tb.sv
module packed_dual_dot_product_unit_tb
   import dual_dot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in, resetn_in, iv, sb, pr, ca, cb, cc, rv, rp;
   dot_op_type op;
   logic [31:0] ev, od, bo, re, ro, saturation_status_reg, control_status_reg, xs, xc;
   logic [66:0] x;
   logic [66:0] q[$];
   int cq[$], cyc, mismatches, compares;
   core_issue_model i_core (.mclk_in(mclk_in), .issue_valid_out(iv), .op_out(op), .side_b_out(sb),
      .predicate_out(pr), .even_out(ev), .odd_out(od), .operand_out(bo));
   packed_dual_dot_product_unit i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .issue_valid_in(iv),
      .op_in(op), .side_b_in(sb), .predicate_in(pr), .even_source_word_in(ev), .odd_source_word_in(od),
      .operand_in(bo), .status_clear_a_in(ca), .status_clear_b_in(cb), .control_sat_clear_in(cc),
      .result_valid_out(rv), .result_pair_out(rp), .result_even_out(re), .result_odd_out(ro),
      .saturation_status_reg_out(saturation_status_reg), .control_status_reg_out(control_status_reg));
   task automatic chk(input string n, input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   function automatic logic signed [33:0] mul(input logic [15:0] a, input logic [15:0] b);
      return $signed(a) * $signed(b);
   endfunction
   function automatic logic [31:0] sat(input logic signed [33:0] s);
      if (s > 34'sh07fffffff) return SAT_POS_WORD;
      if (s < -34'sh080000000) return SAT_NEG_WORD;
      return s[31:0];
   endfunction
   // Packed as pair flag, side, saturation, odd word, even word
   function automatic logic [66:0] model(input dot_op_type k, input logic sd, input logic [31:0] e, o, b);
      logic signed [33:0] s0, s1;
      logic [31:0] r0, r1;
      logic v;
      s0 = mul(b[31:16], o[15:0]) + mul(b[15:0], e[31:16]);
      s1 = mul(o[15:0], b[15:0]) + mul(o[31:16], b[31:16]);
      if (k == low_pair_dual_dot)
      begin
         s1 = s0;
         s0 = mul(e[15:0], b[15:0]) + mul(e[31:16], b[31:16]);
      end
      if (k == byte_halfword_dual_dot)
      begin
         s0 = mul(e[15:0], {{8{b[7]}}, b[7:0]}) + mul(e[31:16], {{8{b[15]}}, b[15:8]});
         s1 = mul(e[15:0], {{8{b[23]}}, b[23:16]}) + mul(e[31:16], {{8{b[31]}}, b[31:24]});
      end
      if (k == high_pair_dual_dot_rounded)
      begin
         s0 = s0 + ROUND_ADD;
         s1 = s1 + ROUND_ADD;
      end
      r0 = sat(s0);
      r1 = sat(s1);
      v = (r0 != s0[31:0]) || (r1 != s1[31:0]);
      if (k == high_pair_dual_dot_rounded)
         return {1'b0, sd, v, 32'h0, r1[31:16], r0[31:16]};
      return {1'b1, sd, v, r1, r0};
   endfunction
   task automatic go(input dot_op_type k, input logic sd, input logic [31:0] e, o, b);
      i_core.issue(k, sd, e, o, b);
      cq.push_back(cyc);
      q.push_back(model(k, sd, e, o, b));
   endtask
   task automatic drain(input string n);
      i_core.idle();
      repeat (7) @(negedge mclk_in);
      $display("test %s done", n);
   endtask
   // Sampled just after each edge so the updates of that edge have landed
   always @(posedge mclk_in)
   begin
      #2;
      cyc = cyc + 1;
      chk("status", saturation_status_reg, xs);
      chk("control", control_status_reg, xc);
      if (rv === 1'b1)
      begin
         x = q.pop_front();
         chk("latency", cyc - cq.pop_front(), 4);
         chk("even", re, x[31:0]);
         chk("odd", ro, x[63:32]);
         chk("pair", {31'h0, rp}, {31'h0, x[66]});
         if (x[64])
         begin
            xs[x[65] ? SSR_SIDE_B_BIT : SSR_SIDE_A_BIT] = 1'b1;
            xc[CSR_SAT_BIT] = 1'b1;
         end
      end
   end
   task automatic t_byte();
      go(byte_halfword_dual_dot, 1'b0, 32'h00050003, 32'h0, 32'h01020304);
      go(byte_halfword_dual_dot, 1'b1, 32'h80008000, 32'h0, 32'h80807f7f);
      go(byte_halfword_dual_dot, 1'b0, 32'h80008000, 32'h0, 32'h80808080);
      drain("byte");
   endtask
   task automatic t_high();
      go(high_pair_dual_dot, 1'b0, 32'h00050003, 32'h00020004, 32'h00070001);
      go(high_pair_dual_dot, 1'b0, 32'h80005678, 32'h12348000, 32'h80008000);
      go(high_pair_dual_dot, 1'b1, 32'h46b416ba, 32'hbbaed169, 32'h340bf73b);
      drain("high");
   endtask
   task automatic t_round();
      go(high_pair_dual_dot_rounded, 1'b0, 32'h46b416ba, 32'hbbaed169, 32'h340bf73b);
      go(high_pair_dual_dot_rounded, 1'b1, 32'h80008000, 32'h80008000, 32'h80008001);
      drain("rounded");
   endtask
   task automatic t_low();
      go(low_pair_dual_dot, 1'b0, 32'h00050003, 32'h00020004, 32'h00070001);
      go(low_pair_dual_dot, 1'b0, 32'h80005678, 32'h12348000, 32'h80008000);
      drain("low");
   endtask
   task automatic t_clear();
      @(negedge mclk_in);
      ca = 1'b1;
      xs[SSR_SIDE_A_BIT] = 1'b0;
      @(negedge mclk_in);
      ca = 1'b0;
      cb = 1'b1;
      cc = 1'b1;
      xs = '0;
      xc = '0;
      @(negedge mclk_in);
      cb = 1'b0;
      cc = 1'b0;
      repeat (2) @(negedge mclk_in);
      $display("test clear done");
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   initial
   begin
      {resetn_in, ca, cb, cc} = 4'h0;
      {xs, xc, cyc, mismatches, compares} = '0;
      repeat (4) @(negedge mclk_in);
      resetn_in = 1'b1;
      t_byte();
      t_high();
      t_round();
      t_low();
      t_clear();
      // A result that never came back would otherwise slip through unnoticed
      chk("pending", q.size(), 32'h0);
      finish_test();
   end
   initial
   begin
      #20000;
      mismatches++;
      finish_test();
   end
endmodule
